// *** tb_timer_output_compare_unit.sv ***
// Self-checking testbench for the timer output compare unit.
`timescale 1ns/1ps
module tb_timer_output_compare_unit;
	logic        clk;
	logic        reset_n   = 1'b1;
	logic        legacy    = 1'b0;
	logic [7:0]  address   = 8'h00;
	logic        read      = 1'b0;
	logic        write     = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        irq;
	logic [11:0] pin;
	int          n_fail    = 0;
	int          checks    = 0;
	toc_timer_output_compare_unit dut (.clk(clk), .reset_n(reset_n), .legacyCompatSetting(legacy),
		.address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .irq(irq), .compareOutputPin(pin));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", s, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// One bus access; the request is held until waitrequest is sampled low.
	task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [31:0] q);
		address <= a;
		writedata <= {16'h0000, d};
		write <= w;
		read <= !w;
		do begin
			@(posedge clk);
		end while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] q;
		acc(1'b1, a, d, q);
	endtask
	task automatic rc(input logic [7:0] a, input logic [15:0] e);
		logic [31:0] q;
		acc(1'b0, a, 16'h0000, q);
		chk($sformatf("register %h", a), q, {16'h0000, e});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic rst(input logic s);
		reset_n <= 1'b0;
		legacy <= s;
		cyc(5);
		reset_n <= 1'b1;
		cyc(4);
	endtask
	task automatic test_ctc();
		int n;
		logic p;
		wr(8'h08, 16'h0002);
		wr(8'h84, 16'h0001);
		wr(8'h00, 16'h0121);
		for (int k = 0; k < 2; k++) begin
			p = pin[0];
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (pin[0] === p && n < 60);
		end
		chk("clear on match period", n, 24);
		wr(8'h00, 16'h0101);
		cyc(3);
		chk("irq raised", irq, 1'b1);
		wr(8'h84, 16'h0000);
		cyc(3);
		chk("irq masked", irq, 1'b0);
		wr(8'h84, 16'h0001);
		rc(8'h80, 16'h0001);
		wr(8'h80, 16'h0001);
		cyc(3);
		chk("irq cleared", irq, 1'b0);
		rc(8'h80, 16'h0000);
	endtask
	task automatic test_pwm_wide();
		logic [31:0] q;
		wr(8'h20, 16'h0002);
		wr(8'h28, 16'hFFFF);
		rc(8'h28, 16'h0000);
		wr(8'h20, 16'h0000);
		rc(8'h28, 16'h0000);
		wr(8'h20, 16'h0002);
		wr(8'h24, 16'h0300);
		wr(8'h20, 16'h0012);
		cyc(300);
		wr(8'h20, 16'h0002);
		acc(1'b0, 8'h24, 16'h0000, q);
		chk("count high byte", q[15:8], 8'h00);
		rc(8'h28, 16'h00FF);
		wr(8'h20, 16'h0300);
		cyc(3);
		chk("wide pin after mode change", pin[3], 1'b0);
	endtask
	// A prescaler restart delays the next divide-by-256 tick; the legacy setting ignores it.
	task automatic test_presc(input logic lg);
		int n;
		logic p;
		wr(8'h04, 16'h0000);
		wr(8'h08, 16'h0000);
		wr(8'h00, 16'h0141);
		for (int k = 0; k < 2; k++) begin
			if (k == 1) begin
				wr(8'h88, 16'h0001);
			end
			p = pin[0];
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (pin[0] === p && n < 300);
		end
		chk("prescaler restart", n, lg ? 253 : 256);
	endtask
	task automatic test_mode_hold();
		wr(8'h48, 16'h0080);
		wr(8'h40, 16'h0111);
		cyc(1);
		chk("pin before match", pin[6], 1'b0);
		cyc(200);
		chk("pin after toggle", pin[6], 1'b1);
		wr(8'h40, 16'h0011);
		cyc(300);
		chk("pin kept while off", pin[6], 1'b1);
		wr(8'h40, 16'h0211);
		cyc(2);
		chk("pin after mode change", pin[6], 1'b1);
		cyc(200);
		chk("pin cleared at match", pin[6], 1'b0);
		wr(8'h40, 16'h0002);
		wr(8'h48, 16'h0055);
		rc(8'h48, 16'h0055);
	endtask
	task automatic test_legacy();
		rc(8'h8C, 16'h0000);
		wr(8'h30, 16'h1234);
		rc(8'h30, 16'h1234);
		wr(8'h68, 16'h4321);
		rc(8'h68, 16'h4321);
		rst(1'b1);
		rc(8'h8C, 16'h0001);
		wr(8'h30, 16'h1234);
		rc(8'h30, 16'h0000);
		wr(8'h68, 16'h4321);
		rc(8'h68, 16'h0000);
		rc(8'h9C, 16'h0000);
		test_presc(1'b1);
		legacy <= 1'b0;
		cyc(2);
		rc(8'h8C, 16'h0001);
	endtask
	initial begin
		#100000;
		n_fail++;
		tally_and_finish();
	end
	initial begin
		rst(1'b0);
		chk("pins after reset", pin, 12'h000);
		test_ctc();
		test_pwm_wide();
		test_mode_hold();
		test_presc(1'b0);
		test_legacy();
		tally_and_finish();
	end
endmodule // tb_timer_output_compare_unit

// *** toc_chk.sv ***
// Port-level checker for the timer output compare unit.
`timescale 1ns/1ps
module toc_chk (
	input logic        clk,
	input logic        reset_n,
	input logic        legacyCompatSetting,
	input logic        read,
	input logic        write,
	input logic [31:0] readdata,
	input logic        waitrequest,
	input logic        irq,
	input logic [11:0] compareOutputPin
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	AST_WAIT_ONE: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low for more than one cycle");
	AST_ANSWER: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("request not answered after one wait cycle");
	AST_NO_SPURIOUS: assert property ($fell(waitrequest) |-> $past(read || write))
		else $error("answer without a request");
	AST_IDLE: assert property (!(read || write) |-> waitrequest)
		else $error("waitrequest low while idle");
	AST_UPPER: assert property (!waitrequest |-> readdata[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	AST_RD_HOLD: assert property (!read |=> $stable(readdata))
		else $error("read data changed without a read");
	AST_PIN_RESET: assert property (@(posedge clk) disable iff (1'b0) !reset_n |-> compareOutputPin == 12'h000)
		else $error("compare pins not zero in reset");
	AST_PIN_INIT: assert property ($rose(reset_n) |-> (compareOutputPin == 12'h000) [*3])
		else $error("compare pins not zero after reset");
	AST_LEGACY: assert property (legacyCompatSetting |-> compareOutputPin[11:9] == 3'h0 && !compareOutputPin[5])
		else $error("absent channel drives its pin");
	AST_NARROW_UNUSED: assert property (compareOutputPin[2:1] == 2'h0 && compareOutputPin[8:7] == 2'h0)
		else $error("unused narrow channel pin set");
	AST_IRQ_RST: assert property ($rose(reset_n) |-> !irq [*3])
		else $error("interrupt high after reset");
	COV_READ: cover property (read && !waitrequest);
	COV_IRQ: cover property ($rose(irq));
	COV_PIN: cover property ($changed(compareOutputPin));
endmodule // toc_chk
bind toc_timer_output_compare_unit toc_chk u_chk (.clk, .reset_n, .legacyCompatSetting, .read, .write, .readdata,
	.waitrequest, .irq, .compareOutputPin);

// *** toc_pkg.sv ***
// Constants, register map and state types of the timer output compare unit.
package toc_pkg;

	localparam int NUM_TIMERS     = 4;
	localparam int NUM_CH         = 3;
	localparam int STAT_PER_TIMER = 4;
	localparam int STAT_OVF_BIT   = 3;

	// Timer slots: two narrow 8-bit timers and two wide 16-bit timers.
	localparam logic [1:0] TMR_NARROW_A    = 2'h0;
	localparam logic [1:0] TMR_WIDE        = 2'h1;
	localparam logic [1:0] TMR_NARROW_B    = 2'h2;
	localparam logic [1:0] TMR_WIDE_SECOND = 2'h3;
	localparam logic [1:0] CH_THIRD        = 2'h2;

	// Waveform modes in the control register.
	typedef enum logic [1:0] {WAVE_NORMAL, WAVE_CTC, WAVE_PWM, WAVE_SPARE} toc_wave_type;

	// Compare output modes, two bits per channel.
	localparam logic [1:0] COM_OFF    = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR  = 2'h2;
	localparam logic [1:0] COM_SET    = 2'h3;

	// PWM resolutions of the wide timers.
	localparam logic [1:0] RES_8  = 2'h0;
	localparam logic [1:0] RES_9  = 2'h1;
	localparam logic [1:0] RES_10 = 2'h2;

	localparam logic [15:0] TOP_8      = 16'h00FF;
	localparam logic [15:0] TOP_9      = 16'h01FF;
	localparam logic [15:0] TOP_10     = 16'h03FF;
	localparam logic [15:0] NARROW_MAX = 16'h00FF;
	localparam logic [15:0] WIDE_MAX   = 16'hFFFF;

	// Clock select codes and prescaler tap masks.
	localparam logic [2:0] CLK_STOP   = 3'h0;
	localparam logic [2:0] CLK_DIV1   = 3'h1;
	localparam logic [2:0] CLK_DIV8   = 3'h2;
	localparam logic [2:0] CLK_DIV64  = 3'h3;
	localparam logic [2:0] CLK_DIV256 = 3'h4;
	localparam logic [7:0] MASK_DIV8   = 8'h07;
	localparam logic [7:0] MASK_DIV64  = 8'h3F;
	localparam logic [7:0] MASK_DIV256 = 8'hFF;

	// Control register fields.
	localparam int CTRL_WAVE_LSB = 0;
	localparam int CTRL_RES_LSB  = 2;
	localparam int CTRL_CLK_LSB  = 4;
	localparam int CTRL_COM_LSB  = 8;

	// Byte address decode: bit 7 selects the global page, bits 6:5 the timer, bits 4:2 the register.
	localparam int ADDR_W          = 8;
	localparam int ADDR_GLOBAL_BIT = 7;
	localparam int ADDR_TIMER_LSB  = 5;
	localparam int ADDR_REG_LSB    = 2;

	localparam logic [2:0] REG_CTRL  = 3'h0;
	localparam logic [2:0] REG_COUNT = 3'h1;
	localparam logic [2:0] REG_CMP0  = 3'h2;
	localparam logic [2:0] REG_CMP2  = 3'h4;

	localparam logic [2:0] REG_STATUS    = 3'h0;
	localparam logic [2:0] REG_MASK      = 3'h1;
	localparam logic [2:0] REG_PRESC_RST = 3'h2;
	localparam logic [2:0] REG_CONFIG    = 3'h3;

	typedef struct packed {
		logic [15:0]            ctrl;
		logic [15:0]            count;
		logic [NUM_CH-1:0][15:0] active;
		logic [NUM_CH-1:0][15:0] hold;
		logic [NUM_CH-1:0]      pending;
		logic [NUM_CH-1:0]      pin;
	} toc_timer_type;

	typedef struct packed {
		toc_timer_type [NUM_TIMERS-1:0] timer;
		logic [7:0]                     prescCnt;
		logic [15:0]                    status;
		logic [15:0]                    mask;
		logic                           legacy;
		logic                           strapped;
		logic                           waitReq;
		logic [31:0]                    readdata;
		logic                           irq;
	} toc_state_type;

endpackage

// *** toc_timer_output_compare_unit.sv ***
// Output compare unit for two 8-bit and two 16-bit timers with an Avalon-MM register slave.
//
// How it works
// - In PWM, compare writes go to a holding register, copied to active at top.
// - Wide timer compare reads return the active value, even with an update pending.
// - Narrow timer compare reads return the holding value while an update is pending.
// - With compare mode off, matches leave the pin; re-enabling resumes from that level.
// - All compare pins are zero after reset.
// - Narrow timers change the pin to a new mode only at the next match.
// - Wide timers leave the pin unchanged after a mode change until a match.
// - In legacy setting the prescaler reset does nothing.
// - Third compare channel of the first wide timer exists only outside legacy setting.
// - Second wide timer exists only outside legacy setting.
// - In PWM the counter bits above the resolution clear on the first prescaled tick.
// - Compare values copied at top have bits above the resolution cleared.
// - Clear on match happens at the end of the last tick period equal to compare.
// - Match flag and pin act at the end of the last tick period equal to compare.
`timescale 1ns/1ps

module toc_timer_output_compare_unit (
	input  wire logic                        clk,
	input  wire logic                        reset_n,
	input  wire logic                        legacyCompatSetting,
	input  wire logic [toc_pkg::ADDR_W-1:0]  address,
	input  wire logic                        read,
	input  wire logic                        write,
	input  wire logic [31:0]                 writedata,
	output logic      [31:0]                 readdata,
	output logic                             waitrequest,
	output logic                             irq,
	output logic      [11:0]                 compareOutputPin
);

	logic [1:0]             rstSync_reg;
	logic                   rstN;
	toc_pkg::toc_state_type s_reg;
	toc_pkg::toc_state_type s_next;

	function automatic logic isWide(input logic [1:0] t);
		return (t == toc_pkg::TMR_WIDE) || (t == toc_pkg::TMR_WIDE_SECOND);
	endfunction

	function automatic logic timerPresent(input logic [1:0] t, input logic legacy);
		return !(legacy && (t == toc_pkg::TMR_WIDE_SECOND));
	endfunction

	function automatic logic chPresent(input logic [1:0] t, input logic [1:0] ch, input logic legacy);
		if (!timerPresent(t, legacy)) begin
			return 1'b0;
		end
		if (!isWide(t)) begin
			return ch == 2'h0;
		end
		return !(legacy && (t == toc_pkg::TMR_WIDE) && (ch == toc_pkg::CH_THIRD));
	endfunction

	function automatic logic [15:0] widthMask(input logic [1:0] t);
		return isWide(t) ? toc_pkg::WIDE_MAX : toc_pkg::NARROW_MAX;
	endfunction

	function automatic logic [15:0] topOf(input logic [1:0] t, input logic [15:0] ctrl);
		logic [15:0] top;
		top = widthMask(t);
		if (ctrl[toc_pkg::CTRL_WAVE_LSB +: 2] == toc_pkg::WAVE_PWM && isWide(t)) begin
			unique case (ctrl[toc_pkg::CTRL_RES_LSB +: 2])
				toc_pkg::RES_8:  top = toc_pkg::TOP_8;
				toc_pkg::RES_9:  top = toc_pkg::TOP_9;
				toc_pkg::RES_10: top = toc_pkg::TOP_10;
				default:         top = toc_pkg::TOP_10;
			endcase
		end
		return top;
	endfunction

	function automatic logic clkTick(input logic [2:0] sel, input logic [7:0] presc);
		unique case (sel)
			toc_pkg::CLK_DIV1:   return 1'b1;
			toc_pkg::CLK_DIV8:   return (presc & toc_pkg::MASK_DIV8) == toc_pkg::MASK_DIV8;
			toc_pkg::CLK_DIV64:  return (presc & toc_pkg::MASK_DIV64) == toc_pkg::MASK_DIV64;
			toc_pkg::CLK_DIV256: return (presc & toc_pkg::MASK_DIV256) == toc_pkg::MASK_DIV256;
			default:             return 1'b0;
		endcase
	endfunction

	function automatic logic applyAction(input logic [1:0] mode, input logic pin);
		unique case (mode)
			toc_pkg::COM_TOGGLE: return !pin;
			toc_pkg::COM_CLEAR:  return 1'b0;
			toc_pkg::COM_SET:    return 1'b1;
			default:             return pin;
		endcase
	endfunction

	// The reset is asserted at once and released through two flip-flops.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rstSync_reg <= 2'h0;
		end else begin
			rstSync_reg <= {rstSync_reg[0], 1'b1};
		end
	end

	assign rstN = rstSync_reg[1];

	always_comb begin
		toc_pkg::toc_timer_type tm;
		logic [15:0] top;
		logic [15:0] cnt;
		logic [15:0] setBits;
		logic [15:0] clrBits;
		logic [15:0] val;
		logic [15:0] rd;
		logic [1:0]  ti;
		logic [1:0]  chIdx;
		logic [2:0]  regSel;
		logic        pwm;
		tm      = '0;
		top     = '0;
		cnt     = '0;
		setBits = '0;
		clrBits = '0;
		val     = '0;
		rd      = '0;
		ti      = address[toc_pkg::ADDR_TIMER_LSB +: 2];
		regSel  = address[toc_pkg::ADDR_REG_LSB +: 3];
		chIdx   = 2'(regSel - toc_pkg::REG_CMP0);
		pwm     = 1'b0;
		s_next  = s_reg;
		s_next.prescCnt = s_reg.prescCnt + 8'h01;

		// The compatibility strap is caught once, on the first cycle out of reset.
		if (!s_reg.strapped) begin
			s_next.strapped = 1'b1;
			s_next.legacy   = legacyCompatSetting;
		end

		for (int t = 0; t < toc_pkg::NUM_TIMERS; t++) begin
			tm  = s_reg.timer[t];
			pwm = tm.ctrl[toc_pkg::CTRL_WAVE_LSB +: 2] == toc_pkg::WAVE_PWM;
			top = topOf(2'(t), tm.ctrl);
			if (timerPresent(2'(t), s_reg.legacy) && clkTick(tm.ctrl[toc_pkg::CTRL_CLK_LSB +: 3], s_reg.prescCnt)) begin
				// Stray high bits left by a software write are dropped before counting on.
				cnt = pwm ? (tm.count & top) : tm.count;
				// A tick ends the period of the current count, so the match acts after its last period.
				for (int ch = 0; ch < toc_pkg::NUM_CH; ch++) begin
					if (chPresent(2'(t), 2'(ch), s_reg.legacy) && cnt == tm.active[ch]) begin
						setBits[t * toc_pkg::STAT_PER_TIMER + ch] = 1'b1;
						// The pin only moves on a match, and a disabled mode keeps its level.
						tm.pin[ch] = applyAction(tm.ctrl[toc_pkg::CTRL_COM_LSB + 2 * ch +: 2], tm.pin[ch]);
					end
				end
				if (cnt == top || (tm.ctrl[toc_pkg::CTRL_WAVE_LSB +: 2] == toc_pkg::WAVE_CTC && cnt == tm.active[0])) begin
					tm.count = '0;
					if (cnt == top) begin
						setBits[t * toc_pkg::STAT_PER_TIMER + toc_pkg::STAT_OVF_BIT] = 1'b1;
						for (int ch = 0; ch < toc_pkg::NUM_CH; ch++) begin
							if (pwm && tm.pending[ch]) begin
								tm.active[ch]  = tm.hold[ch] & top;
								tm.pending[ch] = 1'b0;
							end
						end
					end
				end else begin
					tm.count = cnt + 16'h0001;
				end
			end
			s_next.timer[t] = tm;
		end

		// Bus side: one wait cycle, then the answer.
		s_next.waitReq = !((read || write) && s_reg.waitReq);
		if (write && !s_reg.waitReq) begin
			if (address[toc_pkg::ADDR_GLOBAL_BIT]) begin
				case (regSel)
					toc_pkg::REG_STATUS: clrBits = writedata[15:0];
					toc_pkg::REG_MASK:   s_next.mask = writedata[15:0];
					toc_pkg::REG_PRESC_RST: begin
						if (!s_reg.legacy && writedata[0]) begin
							s_next.prescCnt = '0;
						end
					end
					default: ;
				endcase
			end else if (timerPresent(ti, s_reg.legacy)) begin
				val = writedata[15:0] & widthMask(ti);
				if (regSel == toc_pkg::REG_CTRL) begin
					s_next.timer[ti].ctrl = writedata[15:0];
				end else if (regSel == toc_pkg::REG_COUNT) begin
					s_next.timer[ti].count = val;
				end else if (regSel >= toc_pkg::REG_CMP0 && regSel <= toc_pkg::REG_CMP2 &&
					chPresent(ti, chIdx, s_reg.legacy)) begin
					s_next.timer[ti].hold[chIdx] = val;
					if (s_reg.timer[ti].ctrl[toc_pkg::CTRL_WAVE_LSB +: 2] == toc_pkg::WAVE_PWM) begin
						s_next.timer[ti].pending[chIdx] = 1'b1;
					end else begin
						s_next.timer[ti].active[chIdx]  = val;
						s_next.timer[ti].pending[chIdx] = 1'b0;
					end
				end
			end
		end

		// A match in the same cycle as its clear wins.
		s_next.status = (s_reg.status & ~clrBits) | setBits;
		s_next.irq    = |(s_next.status & s_next.mask);

		if (address[toc_pkg::ADDR_GLOBAL_BIT]) begin
			case (regSel)
				toc_pkg::REG_STATUS: rd = s_reg.status;
				toc_pkg::REG_MASK:   rd = s_reg.mask;
				toc_pkg::REG_CONFIG: rd = {15'h0000, s_reg.legacy};
				default:             rd = '0;
			endcase
		end else if (timerPresent(ti, s_reg.legacy)) begin
			tm = s_reg.timer[ti];
			if (regSel == toc_pkg::REG_CTRL) begin
				rd = tm.ctrl;
			end else if (regSel == toc_pkg::REG_COUNT) begin
				rd = tm.count;
			end else if (regSel >= toc_pkg::REG_CMP0 && regSel <= toc_pkg::REG_CMP2 &&
				chPresent(ti, chIdx, s_reg.legacy)) begin
				if (isWide(ti)) begin
					rd = tm.active[chIdx];
				end else begin
					rd = tm.pending[chIdx] ? tm.hold[chIdx] : tm.active[chIdx];
				end
			end
		end
		if (read && s_reg.waitReq) begin
			s_next.readdata = {16'h0000, rd};
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			s_reg         <= '0;
			s_reg.waitReq <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign readdata    = s_reg.readdata;
	assign waitrequest = s_reg.waitReq;
	assign irq         = s_reg.irq;

	always_comb begin
		for (int t = 0; t < toc_pkg::NUM_TIMERS; t++) begin
			compareOutputPin[t * toc_pkg::NUM_CH +: toc_pkg::NUM_CH] = s_reg.timer[t].pin;
		end
	end

endmodule // toc_timer_output_compare_unit
